// ===== design/sfwp_core.sv
/*
  Write-protection gate of a small serial flash. Samples the SPI pins
  and the protect pins with the core clock, tracks the enable latch,
  power-down, lock registers and block-protect bits, and issues an
  execute pulse only for modifying instructions that pass every check.
  Assumes the serial clock is well below a quarter of i_clk.
*/
// The plain strobed port and the placing of the registers were left to the implementer.
// What this block does
// - A modifying instruction runs only if its clock count is a multiple of 8.
// - Modifying instructions need the enable latch set by the enable command.
// - Latch clears on reset and on completion of each listed instruction except status write.
// - Reset held low freezes the logic in its reset state.
// - In deep power-down, write, program and erase instructions are ignored.
// - Older process: top sector lock pin low makes top 256 pages read-only.
// - Newer process: protect pin low with disable bit set locks status bits.
// - One lock register per 64-Kbyte sector: write-lock and lock-down bits.
// - Write-lock bit set makes modifications of that sector fail.
// - Lock-down bit set freezes that sector's lock bits until reset.
// - Lock bits are volatile and clear to zero on reset.
// - Four sectors: 00 none, 01 sector 3, 10 sectors 2-3, 11 all.
// - Two sectors: 00 none, 01 and 10 sector 1, 11 both.
// - Bulk erase accepted only with both block-protect bits zero.
// - A region is protected if any active mechanism protects it.
// - Modifications are inhibited until the power-up delay expires.
// - Opcode, address and data arrive most significant bit first.
`timescale 1ns/1ps
`include "sfwp_defines.svh"

module sfwp_core
  import sfwp_pkg::*;
#(
  parameter int unsigned PUW_NS = `SFWP_PUW_NS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // SPI pins
  input wire logic i_spi_clk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  // Protect pins
  input wire logic i_top_sector_lock_in,
  input wire logic i_write_protect_n,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // Array sequencer
  output logic o_exec_start,
  output logic [7:0] o_exec_op,
  output logic [23:0] o_exec_addr,
  output logic o_refuse
);

  localparam logic [19:0] PUW_CYC =
    20'((PUW_NS * `SFWP_CLK_MHZ + 999) / 1000);

  sfwp_state_t st_r;
  sfwp_state_t st_nxt;

  function automatic logic [3:0] bp_mask(input logic [1:0] bp,
                                          input logic four);
    logic [3:0] m;
    m = 4'h0;
    if (four) begin
      unique case (bp)
        2'h0: m = 4'h0;
        2'h1: m = 4'h8;
        2'h2: m = 4'hC;
        2'h3: m = 4'hF;
      endcase
    end else begin
      unique case (bp)
        2'h0: m = 4'h0;
        2'h1: m = 4'h2;
        2'h2: m = 4'h2;
        2'h3: m = 4'h3;
      endcase
    end
    return m;
  endfunction

  function automatic logic [1:0] sec_of(input logic [23:0] a,
                                         input logic four);
    return four ? a[17:16] : {1'b0, a[16]};
  endfunction

  function automatic logic [2:0] min_bytes(input logic [7:0] op);
    unique case (op)
      page_write_cmd, page_program_cmd, lock_reg_write_cmd: return 3'h5;
      page_erase_cmd, subsector_erase_cmd, sector_erase_cmd: return 3'h4;
      status_write_cmd: return 3'h2;
      default: return 3'h1;
    endcase
  endfunction

  logic newer;
  logic four;
  logic hw_protected_mode;
  logic [3:0] prot_all;
  logic [3:0] top_mask;

  assign newer = st_r.ctrl[`SFWP_CTRL_NEWER];
  assign four = st_r.ctrl[`SFWP_CTRL_FOUR];
  assign hw_protected_mode = newer & ~st_r.wp_s[1] &
                             st_r.status_write_disable_bit;
  assign top_mask = four ? 4'h8 : 4'h2;
  // Top 256 pages of 256 bytes are exactly the top sector
  assign prot_all = st_r.wl | bp_mask(st_r.bp, four) |
                    ((!newer && !st_r.tsl_s[1]) ? top_mask : 4'h0);

  always_comb begin
    logic sclk_rise;
    logic frame_end;
    logic [7:0] nb;
    logic aligned;
    logic gen_ok;
    logic is_mod;
    logic [1:0] sec;
    logic [31:0] rd;
    sclk_rise = 1'b0;
    frame_end = 1'b0;
    nb = 8'h00;
    aligned = 1'b0;
    gen_ok = 1'b0;
    is_mod = 1'b0;
    sec = 2'h0;
    rd = 32'h0;
    st_nxt = st_r;
    st_nxt.exec_start = 1'b0;
    st_nxt.refuse = 1'b0;
    st_nxt.rdata = 32'h0;

    st_nxt.sclk_s = {st_r.sclk_s[1:0], i_spi_clk};
    st_nxt.cs_s = {st_r.cs_s[1:0], i_spi_cs_n};
    st_nxt.mosi_s = {st_r.mosi_s[0], i_spi_mosi};
    st_nxt.tsl_s = {st_r.tsl_s[0], i_top_sector_lock_in};
    st_nxt.wp_s = {st_r.wp_s[0], i_write_protect_n};
    sclk_rise = st_r.sclk_s[1] & ~st_r.sclk_s[2];
    frame_end = st_r.cs_s[1] & ~st_r.cs_s[2];

    if (!st_r.pu_ok) begin
      st_nxt.pu_cnt = st_r.pu_cnt + 20'h1;
      st_nxt.pu_ok = (st_r.pu_cnt + 20'h1) >= PUW_CYC;
    end

    if (st_r.cs_s[1]) begin
      st_nxt.phase = 3'h0;
      st_nxt.byte_cnt = 3'h0;
    end else if (sclk_rise) begin
      nb = {st_r.shift[6:0], st_r.mosi_s[1]};
      st_nxt.shift = nb;
      st_nxt.phase = st_r.phase + 3'h1;
      if (st_r.phase == 3'h7) begin
        if (st_r.byte_cnt != 3'h7) begin
          st_nxt.byte_cnt = st_r.byte_cnt + 3'h1;
        end
        unique case (st_r.byte_cnt)
          3'h0: st_nxt.opcode = nb;
          3'h1, 3'h2, 3'h3: st_nxt.addr = {st_r.addr[15:0], nb};
          3'h4: st_nxt.data = nb;
          default: ;
        endcase
      end
    end

    if (frame_end) begin
      aligned = st_r.phase == 3'h0 && st_r.byte_cnt != 3'h0;
      aligned = aligned && st_r.byte_cnt >= min_bytes(st_r.opcode);
      sec = sec_of(st_r.addr, four);
      is_mod = 1'b1;
      unique case (st_r.opcode)
        write_enable_cmd, write_disable_cmd, power_down_cmd,
        power_release_cmd: is_mod = 1'b0;
        status_write_cmd, lock_reg_write_cmd, page_write_cmd,
        page_program_cmd, page_erase_cmd, subsector_erase_cmd,
        sector_erase_cmd, bulk_erase_cmd: is_mod = 1'b1;
        default: is_mod = 1'b0;
      endcase
      gen_ok = aligned && st_r.write_enable_latch && st_r.pu_ok;
      if (st_r.dpd) begin
        st_nxt.refuse = is_mod;
        if (aligned && st_r.opcode == power_release_cmd) begin
          st_nxt.dpd = 1'b0;
        end
      end else if (!is_mod) begin
        if (aligned) begin
          unique case (st_r.opcode)
            write_enable_cmd: st_nxt.write_enable_latch = 1'b1;
            write_disable_cmd: st_nxt.write_enable_latch = 1'b0;
            power_down_cmd: st_nxt.dpd = 1'b1;
            default: ;
          endcase
        end
      end else if (!gen_ok) begin
        st_nxt.refuse = 1'b1;
      end else begin
        unique case (st_r.opcode)
          status_write_cmd: begin
            // Status data is the byte right after the opcode
            if (newer && !hw_protected_mode) begin
              st_nxt.bp = st_r.addr[`SFWP_DAT_BP +: 2];
              st_nxt.status_write_disable_bit =
                st_r.addr[`SFWP_DAT_SWD];
            end else begin
              st_nxt.refuse = 1'b1;
            end
          end
          lock_reg_write_cmd: begin
            if (!st_r.ld[sec]) begin
              st_nxt.wl[sec] = st_r.data[`SFWP_DAT_WL];
              st_nxt.ld[sec] = st_r.data[`SFWP_DAT_LD];
              st_nxt.write_enable_latch = 1'b0;
            end else begin
              st_nxt.refuse = 1'b1;
            end
          end
          bulk_erase_cmd: begin
            if (st_r.bp == 2'h0 && prot_all == 4'h0) begin
              st_nxt.exec_start = 1'b1;
              st_nxt.write_enable_latch = 1'b0;
            end else begin
              st_nxt.refuse = 1'b1;
            end
          end
          default: begin
            if (!prot_all[sec]) begin
              st_nxt.exec_start = 1'b1;
              st_nxt.write_enable_latch = 1'b0;
            end else begin
              st_nxt.refuse = 1'b1;
            end
          end
        endcase
        if (st_nxt.exec_start) begin
          st_nxt.exec_op = st_r.opcode;
          st_nxt.exec_addr = st_r.addr;
        end
      end
    end

    // Variant select takes effect next cycle, so it also governs a frame in flight
    if (i_reg_wr && i_reg_addr == `SFWP_OFF_CTRL) begin
      st_nxt.ctrl = i_reg_wdata[1:0];
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `SFWP_OFF_CTRL: rd[1:0] = st_r.ctrl;
        `SFWP_OFF_STAT: begin
          rd[`SFWP_ST_LATCH] = st_r.write_enable_latch;
          rd[`SFWP_ST_DPD] = st_r.dpd;
          rd[`SFWP_ST_HWP] = hw_protected_mode;
          rd[`SFWP_ST_PUOK] = st_r.pu_ok;
          rd[`SFWP_ST_BP +: 2] = st_r.bp;
          rd[`SFWP_ST_SWD] = st_r.status_write_disable_bit;
        end
        `SFWP_OFF_LOCK: begin
          rd[3:0] = st_r.wl;
          rd[`SFWP_LOCK_LD +: 4] = st_r.ld;
        end
        default: rd = 32'h0;
      endcase
      st_nxt.rdata = rd;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
      st_r.sclk_s <= 3'h0;
      st_r.cs_s <= 3'h7;
      st_r.ctrl <= `SFWP_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_reg_rdata = st_r.rdata;
  assign o_exec_start = st_r.exec_start;
  assign o_exec_op = st_r.exec_op;
  assign o_exec_addr = st_r.exec_addr;
  assign o_refuse = st_r.refuse;

  chk_latch_gate: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_r.exec_start |-> $past(st_r.write_enable_latch))
    else $error("execute without enable latch");

  chk_byte_aligned: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_r.exec_start |-> $past(st_r.phase) == 3'h0)
    else $error("execute on a partial byte");

  chk_latch_cleared: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_r.exec_start |-> !st_r.write_enable_latch)
    else $error("latch still set after execute");

  chk_dpd_ignore: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $past(st_r.dpd) |-> !st_r.exec_start)
    else $error("execute during power-down");

  chk_lockdown_sticky: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    ($past(st_r.ld) & ((st_r.wl ^ $past(st_r.wl)) |
      ~st_r.ld)) == 4'h0)
    else $error("locked-down bits changed");

  chk_bulk_bp: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_r.exec_start && st_r.exec_op == bulk_erase_cmd |-> st_r.bp == 2'h0)
    else $error("bulk erase with block protect set");

  chk_sector_prot: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_r.exec_start && st_r.exec_op != bulk_erase_cmd |->
      !$past(prot_all[sec_of(st_r.addr, four)]))
    else $error("execute into a protected sector");

  chk_powerup: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !st_r.pu_ok |=> !st_r.exec_start)
    else $error("execute before power-up delay");

  chk_status_frozen: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    hw_protected_mode |=> $stable(st_r.bp) &&
      $stable(st_r.status_write_disable_bit))
    else $error("status bits changed in protected mode");

  cov_exec: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.exec_start);
  cov_refuse: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.refuse);
  cov_lockdown: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(st_r.ld[0]));
  cov_dpd: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(st_r.dpd));

endmodule

// ===== common/sfwp_defines.svh
/*
  Offsets, field positions, reset values and timing figures of the
  serial flash write-protection block. Assumes a 40 MHz core clock.
*/
`ifndef SFWP_DEFINES_SVH
`define SFWP_DEFINES_SVH

`define SFWP_CLK_MHZ 40
`define SFWP_PUW_NS 1000000

`define SFWP_OFF_CTRL 8'h00
`define SFWP_OFF_STAT 8'h04
`define SFWP_OFF_LOCK 8'h08

`define SFWP_CTRL_NEWER 0
`define SFWP_CTRL_FOUR 1
`define SFWP_CTRL_RST 2'h3

`define SFWP_ST_LATCH 0
`define SFWP_ST_DPD 1
`define SFWP_ST_HWP 2
`define SFWP_ST_PUOK 3
`define SFWP_ST_BP 4
`define SFWP_ST_SWD 6

`define SFWP_LOCK_LD 4

`define SFWP_DAT_WL 0
`define SFWP_DAT_LD 1
`define SFWP_DAT_BP 2
`define SFWP_DAT_SWD 7

`endif

// ===== common/sfwp_pkg.sv
/*
  Types of the serial flash write-protection block.
  Assumes sfwp_defines.svh supplies the numeric constants.
*/
package sfwp_pkg;

  typedef enum logic [7:0] {
    write_enable_cmd = 8'h06,
    write_disable_cmd = 8'h04,
    status_write_cmd = 8'h01,
    lock_reg_write_cmd = 8'hE5,
    page_write_cmd = 8'h0A,
    page_program_cmd = 8'h02,
    page_erase_cmd = 8'hDB,
    subsector_erase_cmd = 8'h20,
    sector_erase_cmd = 8'hD8,
    bulk_erase_cmd = 8'hC7,
    power_down_cmd = 8'hB9,
    power_release_cmd = 8'hAB
  } sfwp_op_t;

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [1:0] mosi_s;
    logic [1:0] tsl_s;
    logic [1:0] wp_s;
    logic [2:0] phase;
    logic [2:0] byte_cnt;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] data;
    logic write_enable_latch;
    logic dpd;
    logic [1:0] bp;
    logic status_write_disable_bit;
    logic [3:0] wl;
    logic [3:0] ld;
    logic [19:0] pu_cnt;
    logic pu_ok;
    logic [1:0] ctrl;
    logic [31:0] rdata;
    logic exec_start;
    logic [7:0] exec_op;
    logic [23:0] exec_addr;
    logic refuse;
  } sfwp_state_t;

endpackage

// ===== verification/sfwp_spi_host.sv
/*
  SPI bus master model, mode 0, for the write-protection bench.
  Assumes it is called just after a rising edge of i_clk.
*/
`timescale 1ns/1ps

module sfwp_spi_host (
  // Core clock
  input wire logic i_clk,
  // SPI pins
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  // Sends the top n bits of v; the clock stands low outside frames
  task automatic send(input logic [39:0] v, input int n);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      o_mosi <= v[39-i];
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    // Released line shows no stale bit
    o_mosi <= ~o_mosi;
    repeat (4) @(posedge i_clk);
  endtask
endmodule

// ===== verification/sfwp_core_test.sv
/*
  Self-checking bench of the write-protection core.
  Assumes sfwp_spi_host drives the SPI pins; power-up delay is shortened.
*/
`timescale 1ns/1ps
`include "sfwp_defines.svh"

module sfwp_core_test
  import sfwp_pkg::*;
;
  localparam int unsigned PUW = 20000;
  typedef struct {logic [39:0] v; int n; logic w; int e;} sfwp_row_t;
  typedef struct {logic [1:0] c; logic [1:0] b; logic [7:0] s;
    logic t; int e;} sfwp_bp_t;
  logic clk = 1'b0, rst_n = 1'b0, sclk, cs_n, mosi, top_sector_lock_in = 1'b1;
  logic wp_n = 1'b1, wr = 1'b0, rd = 1'b0, xs, rf;
  logic [7:0] addr = 8'h00, xop;
  logic [31:0] wdata = 32'h0, rdata;
  logic [23:0] xaddr;
  int mismatches = 0, n_checks = 0, ns = 0, nr = 0;
  sfwp_row_t rows[10];
  sfwp_bp_t bps[11];

  sfwp_spi_host host (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_mosi(mosi));
  sfwp_core #(.PUW_NS(PUW)) DUT (.i_clk(clk), .i_rst_n(rst_n),
    .i_spi_clk(sclk), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi),
    .i_top_sector_lock_in(top_sector_lock_in), .i_write_protect_n(wp_n),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_exec_start(xs), .o_exec_op(xop),
    .o_exec_addr(xaddr), .o_refuse(rf));

  initial begin
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (xs === 1'b1) ns++;
    if (rf === 1'b1) nr++;
  end

  task automatic chk(input string nm, input logic [39:0] e,
      input logic [39:0] s);
    n_checks++;
    if (e !== s) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", e, rdata & m);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // e: 2 start pulse, 1 refuse pulse, 0 neither, -1 not judged
  task automatic frame(input logic [39:0] v, input int n, input int e);
    int s0, r0;
    s0 = ns;
    r0 = nr;
    host.send(v, n);
    repeat (4) @(posedge clk);
    @(negedge clk);
    if (e >= 0) chk("pulses", e, (ns - s0) * 2 + (nr - r0));
  endtask

  task automatic wen();
    frame({write_enable_cmd, 32'h0}, 8, 0);
  endtask

  task automatic prog(input logic [23:0] a, input int e);
    wen();
    frame({page_program_cmd, a, 8'h55}, 40, e);
  endtask

  task automatic sw(input logic [7:0] d, input int e);
    wen();
    frame({status_write_cmd, d, 24'h0}, 16, e);
  endtask

  task automatic lw(input logic [23:0] a, input logic [7:0] d, input int e);
    wen();
    frame({lock_reg_write_cmd, a, d}, 40, e);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #1ms;
    mismatches++;
    report_and_stop();
  end

  initial begin
    rows = '{
      '{{page_program_cmd, 32'h00100055}, 40, 1'b1, 2},
      '{{page_program_cmd, 32'h00100055}, 40, 1'b0, 1},
      '{{page_erase_cmd, 32'h01000000}, 32, 1'b1, 2},
      '{{subsector_erase_cmd, 32'h02000000}, 33, 1'b1, 1},
      '{{subsector_erase_cmd, 32'h02000000}, 32, 1'b0, 2},
      '{{write_disable_cmd, 32'h0}, 8, 1'b1, 0},
      '{{page_program_cmd, 32'h03000055}, 40, 1'b0, 1},
      '{{sector_erase_cmd, 32'h03000000}, 32, 1'b1, 2},
      '{{bulk_erase_cmd, 32'h0}, 8, 1'b1, 2},
      '{{page_write_cmd, 32'h000100AA}, 40, 1'b1, 2}};
    bps = '{'{2'h3, 2'h1, 8'h03, 1'b1, 1}, '{2'h3, 2'h1, 8'h02, 1'b1, 2},
      '{2'h3, 2'h2, 8'h02, 1'b1, 1}, '{2'h3, 2'h2, 8'h01, 1'b1, 2},
      '{2'h3, 2'h3, 8'h00, 1'b1, 1}, '{2'h1, 2'h1, 8'h01, 1'b1, 1},
      '{2'h1, 2'h2, 8'h01, 1'b1, 1}, '{2'h1, 2'h2, 8'h00, 1'b1, 2},
      '{2'h1, 2'h3, 8'h00, 1'b1, 1}, '{2'h2, 2'h0, 8'h03, 1'b0, 1},
      '{2'h2, 2'h0, 8'h03, 1'b1, 2}};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rreg(`SFWP_OFF_CTRL, 32'hFF, 32'h3);
    rreg(`SFWP_OFF_STAT, 32'hFF, 32'h0);
    rreg(`SFWP_OFF_LOCK, 32'hFF, 32'h0);
    prog(24'h001000, 1);
    repeat (800) @(posedge clk);
    rreg(`SFWP_OFF_STAT, 32'h08, 32'h08);
    $display("test reset done");
    foreach (rows[i]) begin
      if (rows[i].w) wen();
      frame(rows[i].v, rows[i].n, rows[i].e);
      if (rows[i].e == 2) chk("op", rows[i].v[39:32], xop);
      if (rows[i].e == 2 && rows[i].n >= 32)
        chk("addr", rows[i].v[31:8], xaddr);
    end
    rreg(`SFWP_OFF_STAT, 32'h01, 32'h0);
    $display("test rows done");
    wen();
    frame({power_down_cmd, 32'h0}, 8, 0);
    prog(24'h001000, 1);
    rreg(`SFWP_OFF_STAT, 32'h02, 32'h02);
    frame({power_release_cmd, 32'h0}, 8, 0);
    prog(24'h001000, 2);
    $display("test power-down done");
    lw(24'h010000, 8'h01, -1);
    rreg(`SFWP_OFF_STAT, 32'h01, 32'h0);
    rreg(`SFWP_OFF_LOCK, 32'hFF, 32'h02);
    prog(24'h010000, 1);
    lw(24'h020000, 8'h03, -1);
    rreg(`SFWP_OFF_LOCK, 32'hFF, 32'h46);
    lw(24'h020000, 8'h00, 1);
    rreg(`SFWP_OFF_LOCK, 32'hFF, 32'h46);
    wen();
    frame({bulk_erase_cmd, 32'h0}, 8, 1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rreg(`SFWP_OFF_LOCK, 32'hFF, 32'h0);
    rreg(`SFWP_OFF_STAT, 32'h01, 32'h0);
    repeat (800) @(posedge clk);
    $display("test locks done");
    foreach (bps[i]) begin
      wreg(`SFWP_OFF_CTRL, 32'h3);
      sw({4'h0, bps[i].b, 2'h0}, -1);
      wreg(`SFWP_OFF_CTRL, {30'h0, bps[i].c});
      top_sector_lock_in <= bps[i].t;
      prog({bps[i].s, 16'h0}, bps[i].e);
      @(posedge clk) top_sector_lock_in <= 1'b1;
    end
    // Older process takes no status write
    sw(8'h0C, 1);
    wreg(`SFWP_OFF_CTRL, 32'h3);
    sw(8'h04, -1);
    wen();
    frame({bulk_erase_cmd, 32'h0}, 8, 1);
    $display("test block protect done");
    @(posedge clk) wp_n <= 1'b0;
    sw(8'h80, -1);
    rreg(`SFWP_OFF_STAT, 32'h74, 32'h44);
    sw(8'h8C, 1);
    rreg(`SFWP_OFF_STAT, 32'h74, 32'h44);
    $display("test hardware protect done");
    report_and_stop();
  end
endmodule
